// file: logic/rsr_defines.svh
// Offsets, field positions, reset values and codes of the sync, ramp and
// identifier registers.
// Assumes inclusion by bare name from the register module, the checker and the bench.
`ifndef RSR_DEFINES_SVH
`define RSR_DEFINES_SVH

`define RSR_ADDR_SYNC      8'h05
`define RSR_ADDR_RAMP      8'h06
`define RSR_ADDR_ID        8'h08
`define RSR_RST_SYNC       8'h00
`define RSR_RST_RAMP       8'h01
`define RSR_SYNC_MASK      8'hc0
`define RSR_RAMP_MASK      8'hfa
`define RSR_DIE_ID_DEFAULT 8'h37
`define RSR_FREQ_26M       2'h0
`define RSR_FREQ_13M       2'h1
`define RSR_FREQ_19M2A     2'h2
`define RSR_FREQ_19M2B     2'h3
`define RSR_SLEW_HI        3'h7
`define RSR_SLEW_LO        3'h5
`define RSR_PSAVE_BIT      4
`define RSR_OSC_BIT        3
`define RSR_RDOWN_BIT      1

`endif

// file: logic/rsr_pkg.sv
// Types shared by the regulator sync, ramp and identifier register bank.
// Assumes the defines header is on the include path.
package rsr_pkg;

    typedef enum logic [1:0] {
        RSR_CLK_26M,
        RSR_CLK_13M,
        RSR_CLK_19M2
    } rsr_clk_t;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } rsr_bus_req_t;

    typedef struct packed {
        logic [7:0] sync;
        logic [7:0] ramp;
        logic [7:0] rdata;
        logic       rvalid;
        rsr_clk_t   clk_sel;
        logic [7:0] slew_onehot;
        logic       psave_only;
        logic       osc_run;
        logic       zcd_off;
        logic       follow_ext;
    } rsr_state_t;

endpackage

// file: logic/rsr_regs.sv
// Sync, ramp and identifier registers of the step-down regulator.
// Assumes an upstream serial-bus slave that delivers single-cycle byte
// read and write strobes, and a lockout flag from the supply monitors.
// The forced-PWM and sync-enable bits arrive as levels from the per-mode
// registers elsewhere in the bank.
// Lockout is a level; while it is high both registers hold their reset
// values.
`timescale 1ns/10ps
`include "rsr_defines.svh"

module rsr_regs
    import rsr_pkg::*;
#(
    parameter logic [7:0] DIE_ID = `RSR_DIE_ID_DEFAULT  // Arbitrary value.
) (
    input  wire logic         clk,
    input  wire logic         rstn,
    input  wire logic         undervoltage_lockout,
    input  wire rsr_bus_req_t bus_req,
    input  wire logic         forced_pwm_select,
    input  wire logic         ext_clock_follow_enable,
    output logic [7:0]        rdata,
    output logic              rvalid,
    output rsr_clk_t          clk_sel,
    output logic [7:0]        slew_onehot,
    output logic              power_save_lock,
    output logic              oscillator_keep_running,
    output logic              zero_cross_disable,
    output logic              forced_pwm,
    output logic              ext_clock_follow
);

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    rsr_state_t st_r;
    rsr_state_t st_nxt;
    logic       fpwm_r;

    // ----------------------------------------------------------------
    // Bus fields
    // ----------------------------------------------------------------
    logic       bus_wr;
    logic       bus_rd;
    logic [7:0] bus_addr;
    logic [7:0] bus_wdata;

    assign bus_wr    = bus_req.wr;
    assign bus_rd    = bus_req.rd;
    assign bus_addr  = bus_req.addr;
    assign bus_wdata = bus_req.wdata;

    // ----------------------------------------------------------------
    // Decode signals
    // ----------------------------------------------------------------
    logic       wr_sync;
    logic       wr_ramp;
    logic       rd_sync;
    logic       rd_ramp;
    logic       rd_id;
    logic [7:0] sync_wval;
    logic [7:0] ramp_wval;
    logic [7:0] sync_nxt;
    logic [7:0] ramp_nxt;
    logic [2:0] slew_code;
    logic [7:0] slew_dec;
    logic       psave_req;
    logic       osc_req;
    logic       zcd_req;

    // ----------------------------------------------------------------
    // Address decode
    // ----------------------------------------------------------------
    assign wr_sync = bus_wr && (bus_addr == `RSR_ADDR_SYNC);
    assign wr_ramp = bus_wr && (bus_addr == `RSR_ADDR_RAMP);
    assign rd_sync = bus_rd && (bus_addr == `RSR_ADDR_SYNC);
    assign rd_ramp = bus_rd && (bus_addr == `RSR_ADDR_RAMP);
    assign rd_id   = bus_rd && (bus_addr == `RSR_ADDR_ID);

    // ----------------------------------------------------------------
    // Write path
    // ----------------------------------------------------------------
    // Reserved bits are dropped on the way in, so they read zero except ramp bit 0, which reset and lockout set to one.
    localparam logic [7:0] SYNC_KEEP = `RSR_SYNC_MASK;
    localparam logic [7:0] RAMP_KEEP = `RSR_RAMP_MASK;

    generate
        for (genvar b = 0; b < 8; b++) begin : g_mask
            assign sync_wval[b] = bus_wdata[b] & SYNC_KEEP[b];
            assign ramp_wval[b] = bus_wdata[b] & RAMP_KEEP[b];
        end
    endgenerate

    // Lockout overrides a write in the same cycle.
    assign sync_nxt = undervoltage_lockout ? `RSR_RST_SYNC :
                      wr_sync              ? sync_wval     :
                                             st_r.sync;

    assign ramp_nxt = undervoltage_lockout ? `RSR_RST_RAMP :
                      wr_ramp              ? ramp_wval     :
                                             st_r.ramp;

    // ----------------------------------------------------------------
    // Mode inputs
    // ----------------------------------------------------------------
    // Both bits come from the per-mode registers outside this bank and
    // are retimed once so that every output leaves a flip-flop.
    logic fpwm_in;
    logic follow_in;

    assign fpwm_in   = forced_pwm_select;
    assign follow_in = ext_clock_follow_enable;

    // ----------------------------------------------------------------
    // Field decode
    // ----------------------------------------------------------------
    assign slew_code = ramp_nxt[`RSR_SLEW_HI:`RSR_SLEW_LO];
    assign psave_req = ramp_nxt[`RSR_PSAVE_BIT] & ~fpwm_in;
    assign osc_req   = ramp_nxt[`RSR_OSC_BIT];
    assign zcd_req   = ramp_nxt[`RSR_RDOWN_BIT];

    // Each slew code lights one bit; code n is the fastest rate halved n times.
    generate
        for (genvar g = 0; g < 8; g++) begin : g_slew
            assign slew_dec[g] = (slew_code == 3'(g));
        end
    endgenerate

    // ----------------------------------------------------------------
    // Next-state logic
    // ----------------------------------------------------------------
    always_comb begin
        st_nxt        = st_r;
        st_nxt.sync   = sync_nxt;
        st_nxt.ramp   = ramp_nxt;
        st_nxt.rvalid = 1'b0;

        // Read data holds until the next read strobe.
        if (bus_rd) begin
            st_nxt.rvalid = 1'b1;
            if (rd_sync) begin
                st_nxt.rdata = st_r.sync;
            end else if (rd_ramp) begin
                st_nxt.rdata = st_r.ramp;
            end else if (rd_id) begin
                st_nxt.rdata = DIE_ID;
            end else begin
                st_nxt.rdata = 8'h00;
            end
        end

        // Both upper codes select the same clock frequency.
        unique case (sync_nxt[7:6])
            `RSR_FREQ_26M: begin
                st_nxt.clk_sel = RSR_CLK_26M;
            end
            `RSR_FREQ_13M: begin
                st_nxt.clk_sel = RSR_CLK_13M;
            end
            `RSR_FREQ_19M2A: begin
                st_nxt.clk_sel = RSR_CLK_19M2;
            end
            `RSR_FREQ_19M2B: begin
                st_nxt.clk_sel = RSR_CLK_19M2;
            end
        endcase

        st_nxt.slew_onehot = slew_dec;
        st_nxt.psave_only  = psave_req;
        st_nxt.osc_run     = osc_req;
        st_nxt.zcd_off     = zcd_req;
        st_nxt.follow_ext  = follow_in;
    end

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            st_r.sync        <= `RSR_RST_SYNC;
            st_r.ramp        <= `RSR_RST_RAMP;
            st_r.rdata       <= 8'h00;
            st_r.rvalid      <= 1'b0;
            st_r.clk_sel     <= RSR_CLK_26M;
            st_r.slew_onehot <= 8'h01;
            st_r.psave_only  <= 1'b0;
            st_r.osc_run     <= 1'b0;
            st_r.zcd_off     <= 1'b0;
            st_r.follow_ext  <= 1'b0;
            fpwm_r           <= 1'b0;
        end else begin
            st_r   <= st_nxt;
            fpwm_r <= fpwm_in;
        end
    end

    assign rdata                   = st_r.rdata;
    assign rvalid                  = st_r.rvalid;
    assign clk_sel                 = st_r.clk_sel;
    assign slew_onehot             = st_r.slew_onehot;
    assign power_save_lock         = st_r.psave_only;
    assign oscillator_keep_running = st_r.osc_run;
    assign zero_cross_disable      = st_r.zcd_off;
    assign forced_pwm              = fpwm_r;
    assign ext_clock_follow        = st_r.follow_ext;

endmodule

// file: verification/rsr_host.sv
// Host model that issues single-cycle register strobes.
// Assumes the bench calls xfer and nothing else drives the bus.
`timescale 1ns/10ps
module rsr_host import rsr_pkg::*; (
    input  wire logic   clk,
    output rsr_bus_req_t bus_req
);
    initial bus_req = '0;
    task automatic xfer(input logic w, input logic [7:0] a, d);
        @(negedge clk);
        bus_req = '{w, !w, a, d};
        @(negedge clk);
        bus_req = '{1'b0, 1'b0, ~a, ~d};
    endtask
endmodule

// file: verification/rsr_regs_properties.sv
// Port assertions for the sync, ramp and identifier registers.
// Assumes the package and the defines header are compiled first.
`timescale 1ns/10ps
`include "rsr_defines.svh"
module rsr_regs_props import rsr_pkg::*;
    #(parameter logic [7:0] DIE_ID = `RSR_DIE_ID_DEFAULT) (
    input wire logic clk, rstn, undervoltage_lockout, forced_pwm_select,
    input wire logic ext_clock_follow_enable, rvalid, power_save_lock,
    input wire logic oscillator_keep_running, zero_cross_disable, forced_pwm,
    input wire logic ext_clock_follow,
    input wire rsr_bus_req_t bus_req,
    input wire logic [7:0] rdata, slew_onehot,
    input wire rsr_clk_t clk_sel
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    wire wok = bus_req.wr && !undervoltage_lockout;
    wire w5 = wok && bus_req.addr == `RSR_ADDR_SYNC;
    wire w6 = wok && bus_req.addr == `RSR_ADDR_RAMP;
    property p_uv; undervoltage_lockout |=> clk_sel == RSR_CLK_26M &&
        slew_onehot == 8'h01 && !zero_cross_disable; endproperty
    a_uv: assert property (p_uv) else $error("lockout reset");
    property p_clk; w5 |=> clk_sel == ($past(bus_req.wdata[7]) ?
        RSR_CLK_19M2 : rsr_clk_t'($past(bus_req.wdata[7:6]))); endproperty
    a_clk: assert property (p_clk) else $error("clock select");
    property p_slew;
        w6 |=> slew_onehot == 8'h01 << $past(bus_req.wdata[7:5]); endproperty
    a_slew: assert property (p_slew) else $error("slew");
    property p_psave; w6 && !forced_pwm_select |=>
        power_save_lock == $past(bus_req.wdata[4]); endproperty
    a_psave: assert property (p_psave) else $error("power save");
    property p_osc;
        w6 |=> oscillator_keep_running == $past(bus_req.wdata[3]); endproperty
    a_osc: assert property (p_osc) else $error("oscillator");
    property p_zcd;
        w6 |=> zero_cross_disable == $past(bus_req.wdata[1]); endproperty
    a_zcd: assert property (p_zcd) else $error("ramp down");
    property p_fpwm; 1 |=> forced_pwm == $past(forced_pwm_select); endproperty
    a_fpwm: assert property (p_fpwm) else $error("forced pwm");
    property p_ext;
        1 |=> ext_clock_follow == $past(ext_clock_follow_enable); endproperty
    a_ext: assert property (p_ext) else $error("follow");
    property p_id; bus_req.rd && bus_req.addr == `RSR_ADDR_ID |=>
        rvalid && rdata == DIE_ID; endproperty
    a_id: assert property (p_id) else $error("identifier");
    c_uv: cover property (undervoltage_lockout);
    c_w6: cover property (w6);
    c_rd: cover property (rvalid);
endmodule
bind rsr_regs rsr_regs_props #(.DIE_ID(DIE_ID)) u_props (.*);

// file: verification/regulator_sync_ramp_id_regs_bench.sv
// Self-checking bench for the sync, ramp and identifier registers.
// Assumes the package, defines, host model and checker are compiled first.
`timescale 1ns/10ps
`include "rsr_defines.svh"
`define CHK(n, e, s) begin samples_checked++; if ((s) !== (e)) begin \
    num_errors++; $display("CHECK FAILED %s exp %h got %h", n, e, s); end end
module regulator_sync_ramp_id_regs_bench import rsr_pkg::*; ;
    logic clk = 0, rstn = 0, uv = 0, fps = 0, ecf = 0, rv, pl, ok, zd, fp, ef;
    logic [7:0] rdt, sl;
    rsr_clk_t cs;
    rsr_bus_req_t req;
    int num_errors = 0, samples_checked = 0, seed = 32'he1bc, sm = 0, rm = 1, x;
    initial forever #2 clk = ~clk;
    rsr_host u_host (.clk(clk), .bus_req(req));
    rsr_regs u_dut (.clk(clk), .rstn(rstn), .undervoltage_lockout(uv),
        .bus_req(req), .forced_pwm_select(fps), .ext_clock_follow_enable(ecf),
        .rdata(rdt), .rvalid(rv), .clk_sel(cs), .slew_onehot(sl),
        .power_save_lock(pl), .oscillator_keep_running(ok),
        .zero_cross_disable(zd), .forced_pwm(fp), .ext_clock_follow(ef));
    task automatic final_report;
        if (num_errors == 0 && samples_checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic chk_out;
        x = sm >> 6;
        `CHK("clk_sel", rsr_clk_t'(x == 3 ? 2 : x), cs)
        `CHK("slew", 8'(1 << (rm >> 5)), sl)
        `CHK("psave", logic'(rm[4] & !fps), pl)
        `CHK("osc", logic'(rm[3]), ok)
        `CHK("zcd", logic'(rm[1]), zd)
        `CHK("fpwm", fps, fp)
        `CHK("follow", ecf, ef)
    endtask
    task automatic wr(input logic [7:0] a, d);
        u_host.xfer(1, a, d);
        if (a == 8'h05) sm = d & 8'hc0;
        if (a == 8'h06) rm = d & 8'hfa;
        chk_out;
    endtask
    task automatic rd(input logic [7:0] a);
        u_host.xfer(0, a, 8'h00);
        x = a == 5 ? sm : a == 6 ? rm : a == 8 ? `RSR_DIE_ID_DEFAULT : 0;
        `CHK("rvalid", 1'b1, rv)
        `CHK("rdata", 8'(x), rdt)
    endtask
    initial begin
        repeat (10) @(posedge clk);
        @(negedge clk) rstn = 1;
        for (int a = 4; a < 10; a++) rd(8'(a));
        for (int i = 0; i < 8; i++) begin
            fps = i[0];
            ecf = i[1];
            wr(8'h05, 8'(i << 6) | 8'($random(seed)) & 8'h3f);
            wr(8'h06, 8'(i << 5) | 8'($random(seed)) & 8'h1f);
            rd(8'h05);
            rd(8'h06);
        end
        wr(8'h08, 8'hff);
        rd(8'h08);
        @(negedge clk) uv = 1;
        @(negedge clk) uv = 0;
        sm = 0;
        rm = 1;
        chk_out;
        rd(8'h05);
        rd(8'h06);
        final_report;
    end
    initial begin
        #2000;
        num_errors++;
        final_report;
    end
endmodule
